// file: core/sfwp_core.sv
`timescale 1ns/1ps
module sfwp_core
    import sfwp_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CHIP_SEL_N,
    input wire logic SER_CLK,
    input wire logic SER_IN,
    input wire logic WRITE_GUARD_N,
    output logic SER_OUT,
    output logic SER_OUT_EN,
    output logic [7:0] FLASH_STATUS,
    output logic QUAD_IO_ENABLE,
    output logic OP_START,
    output logic [7:0] OP_CMD,
    output logic [23:0] OP_ADDR,
    input wire logic OP_DONE
);
    // two-stage synchronisers for the chip-select, serial clock, serial data and write-guard pins
    logic [1:0] cs_sync_ff, sck_sync_ff, si_sync_ff, wg_sync_ff;
    logic sck_last_ff, cs_last_ff;
    logic [7:0] instr_ff;
    logic [23:0] addr_ff;
    logic [5:0] bit_cnt_ff;
    logic [2:0] frac_ff;
    logic [3:0] prot_ff;
    logic quad_ff, lock_ff, latch_ff;
    sfwp_state_t state_ff;
    logic [7:0] busy_cnt_ff;
    logic [7:0] shift_out_ff;
    logic op_start_ff;
    logic [7:0] op_cmd_ff;
    logic [23:0] op_addr_ff;

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            cs_sync_ff <= 2'h3;
            sck_sync_ff <= 2'h0;
            si_sync_ff <= 2'h0;
            wg_sync_ff <= 2'h3;
            sck_last_ff <= 1'b0;
            cs_last_ff <= 1'b1;
        end else begin
            cs_sync_ff <= {cs_sync_ff[0], CHIP_SEL_N};
            sck_sync_ff <= {sck_sync_ff[0], SER_CLK};
            si_sync_ff <= {si_sync_ff[0], SER_IN};
            wg_sync_ff <= {wg_sync_ff[0], WRITE_GUARD_N};
            sck_last_ff <= sck_sync_ff[1];
            cs_last_ff <= cs_sync_ff[1];
        end
    end

    wire selected = !cs_sync_ff[1];
    wire sck_rise = selected && sck_sync_ff[1] && !sck_last_ff;
    wire sck_fall = selected && !sck_sync_ff[1] && sck_last_ff;
    wire frame_end = cs_sync_ff[1] && !cs_last_ff;
    wire si_bit = si_sync_ff[1];
    wire busy = (state_ff == SFWP_BUSY);

    // protect range decode: lo..hi inclusive, empty when none
    wire [3:0] prot_code = prot_ff;
    wire [2:0] prot_size = prot_code[2:0];
    wire prot_all = (prot_size == PROT_ALL_CODE[2:0]);
    wire prot_none = (prot_size == 3'h0);
    // one wider than the block index so that a count of the whole array fits
    wire [6:0] blk_total = {1'b0, LAST_BLOCK} + 7'h01;
    wire [6:0] prot_count = prot_all ? blk_total : (7'h01 << (prot_size - 3'h1));
    wire [5:0] blk = addr_ff[BLK_MSB:BLK_LSB];
    wire [6:0] blk_w = {1'b0, blk};
    wire in_upper = (blk_w >= (blk_total - prot_count));
    wire in_lower = (blk_w < prot_count);
    wire target_prot = !prot_none && (prot_all || (prot_code[3] ? in_lower : in_upper));

    wire cmd_prog = (instr_ff == CMD_PAGE_PROG) || (instr_ff == CMD_QUAD_PROG);
    wire cmd_erase = (instr_ff == CMD_SECTOR_ERASE_A) || (instr_ff == CMD_SECTOR_ERASE_B)
        || (instr_ff == CMD_BLOCK_ERASE);
    wire cmd_full = (instr_ff == CMD_FULL_ERASE_A) || (instr_ff == CMD_FULL_ERASE_B);
    wire cmd_swr = (instr_ff == CMD_STATUS_WRITE);
    wire whole_bytes = (frac_ff == BYTE_MASK);
    wire swr_locked = lock_ff && !wg_sync_ff[1];
    // the status byte is the first after the command; later bytes pushed it
    // further up the address shifter, so shift it back down by the excess
    wire [23:0] swr_word = addr_ff >> (bit_cnt_ff - CNT_STATUS_BITS);
    wire [7:0] swr_byte = swr_word[7:0];
    wire can_write = frame_end && latch_ff && !busy && whole_bytes;
    wire do_swr = can_write && cmd_swr && (bit_cnt_ff >= CNT_STATUS_BITS) && !swr_locked;
    wire do_prog = can_write && cmd_prog && (bit_cnt_ff >= CNT_ADDR_BITS) && !target_prot;
    wire do_erase = can_write && cmd_erase && (bit_cnt_ff == CNT_ADDR_BITS) && !target_prot;
    wire do_full = can_write && cmd_full && (bit_cnt_ff == CNT_CMD_BITS)
        && (prot_code == 4'h0);
    wire do_arm = frame_end && (instr_ff == CMD_WRITE_ARM) && (bit_cnt_ff == CNT_CMD_BITS);
    wire do_disarm = frame_end && (instr_ff == CMD_WRITE_DISARM)
        && (bit_cnt_ff == CNT_CMD_BITS);
    wire start_op = do_swr || do_prog || do_erase || do_full;
    wire op_finished = busy && (busy_cnt_ff == 8'h00) && OP_DONE;
    wire [5:0] cnt_sat = (bit_cnt_ff == CNT_ADDR_BITS) ? bit_cnt_ff : bit_cnt_ff + 6'h01;

    // serial shift-in, most significant bit first
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || frame_end) begin
            instr_ff <= 8'h00;
            addr_ff <= 24'h00_0000;
            bit_cnt_ff <= 6'h00;
            frac_ff <= 3'h0;
        end else if (sck_rise) begin
            frac_ff <= frac_ff + 3'h1;
            bit_cnt_ff <= cnt_sat;
            if (bit_cnt_ff < CNT_CMD_BITS)
                instr_ff <= {instr_ff[6:0], si_bit};
            else if (bit_cnt_ff < CNT_ADDR_BITS)
                addr_ff <= {addr_ff[22:0], si_bit};
        end
    end

    // status: non-volatile bits kept in core flops
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            prot_ff <= STATUS_RESET[BIT_PROT_LO +: 4];
            quad_ff <= STATUS_RESET[BIT_QUAD];
            lock_ff <= STATUS_RESET[BIT_LOCK];
        end else if (do_swr) begin
            prot_ff <= swr_byte[BIT_PROT_LO +: 4];
            quad_ff <= swr_byte[BIT_QUAD];
            lock_ff <= swr_byte[BIT_LOCK];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N)
            latch_ff <= STATUS_RESET[BIT_LATCH];
        else if (do_arm && !busy)
            latch_ff <= 1'b1;
        else if (do_disarm || op_finished)
            latch_ff <= 1'b0;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_ff <= SFWP_IDLE;
            busy_cnt_ff <= 8'h00;
        end else begin
            case (state_ff)
                SFWP_IDLE: begin
                    if (start_op) begin
                        state_ff <= SFWP_BUSY;
                        busy_cnt_ff <= BUSY_CYCLES;
                    end
                end
                SFWP_BUSY: begin
                    if (busy_cnt_ff != 8'h00)
                        busy_cnt_ff <= busy_cnt_ff - 8'h01;
                    else if (OP_DONE)
                        state_ff <= SFWP_IDLE;
                end
                default: state_ff <= SFWP_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            op_start_ff <= 1'b0;
            op_cmd_ff <= 8'h00;
            op_addr_ff <= 24'h00_0000;
        end else begin
            op_start_ff <= start_op && !do_swr;
            if (start_op) begin
                op_cmd_ff <= instr_ff;
                op_addr_ff <= addr_ff;
            end
        end
    end

    // status readback, shifted out on falling serial clock
    wire [7:0] status_now = {lock_ff, quad_ff, prot_ff, latch_ff, busy};
    wire rd_status = selected && (instr_ff == CMD_READ_STATUS) && (bit_cnt_ff >= CNT_CMD_BITS);
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || !selected)
            shift_out_ff <= 8'h00;
        else if (sck_fall && rd_status)
            shift_out_ff <= (frac_ff == BYTE_MASK) ? status_now : {shift_out_ff[6:0], 1'b0};
    end

    assign SER_OUT = shift_out_ff[7];
    assign SER_OUT_EN = rd_status;
    assign FLASH_STATUS = status_now;
    assign QUAD_IO_ENABLE = quad_ff;
    assign OP_START = op_start_ff;
    assign OP_CMD = op_cmd_ff;
    assign OP_ADDR = op_addr_ff;
endmodule

// file: core/sfwp_pkg.sv
// Behaviour
// - status bit 0 is read-only busy flag, set while an internal write runs.
// - status bit 1 is volatile write latch flag, cleared by default.
// - status bits 2..5 are four writable range-protect bits.
// - status bit 6 is writable quad enable, default off.
// - status bit 7 is writable status lock bit, default off.
// - top bit 0: codes 1..6 protect uppermost 1,2,4,8,16,32 blocks.
// - top bit 1: codes 9..14 protect lowest 1,2,4,8,16,32 blocks.
// - codes 0111 and 1111 protect all sixty-four blocks.
// - program or erase into a protected block is refused.
// - full erase runs only when all four protect bits are zero.
// - write-type commands execute only if clock count is a multiple of eight.
// - status write ignored while lock bit set and write-guard pin low.
// - write-type commands ignored unless write latch flag is set.
// - write latch clears on operation completion and on write-disarm.
// - eight-bit instruction register, shifted in most significant bit first.
// - serial input sampled on rising serial clock while selected.
// - transaction starts with one command byte, then address and/or data.
package sfwp_pkg;
    localparam logic [7:0] CMD_WRITE_ARM = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISARM = 8'h04;
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
    localparam logic [7:0] CMD_QUAD_PROG = 8'h32;
    localparam logic [7:0] CMD_SECTOR_ERASE_A = 8'hD7;
    localparam logic [7:0] CMD_SECTOR_ERASE_B = 8'h20;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] CMD_FULL_ERASE_A = 8'hC7;
    localparam logic [7:0] CMD_FULL_ERASE_B = 8'h60;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam int BIT_BUSY = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_PROT_LO = 2;
    localparam int BIT_QUAD = 6;
    localparam int BIT_LOCK = 7;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [3:0] PROT_ALL_CODE = 4'h7;
    localparam logic [5:0] LAST_BLOCK = 6'h3F;
    localparam int BLK_MSB = 21;
    localparam int BLK_LSB = 16;
    localparam logic [5:0] CNT_CMD_BITS = 6'h08;
    localparam logic [5:0] CNT_STATUS_BITS = 6'h10;
    localparam logic [5:0] CNT_ADDR_BITS = 6'h20;
    localparam logic [2:0] BYTE_MASK = 3'h0;
    // busy count of a committed write, in core cycles; busy then holds until OP_DONE
    localparam logic [7:0] BUSY_CYCLES = 8'h40;
    typedef enum logic [1:0] {
        SFWP_IDLE = 2'b00,
        SFWP_BUSY = 2'b01
    } sfwp_state_t;
endpackage

// file: dv/sfwp_host.sv
`timescale 1ns/1ps
module sfwp_host (
    input wire logic clk,
    input wire logic so,
    output logic cs_n,
    output logic sck,
    output logic si
);
    logic [31:0] rx;
    initial begin
        rx = 32'h0000_0000;
        cs_n = 1'h1;
        sck = 1'h0;
        si = 1'h0;
    end
    // mode 0: clock rests low outside frames, data moves on its falling edge
    task automatic frame(input logic [31:0] d, input int n);
        @(negedge clk);
        cs_n = 1'h0;
        repeat (4) @(negedge clk);
        for (int k = n - 1; k >= 0; k--) begin
            si = d[k];
            repeat (4) @(negedge clk);
            rx = {rx[30:0], so};
            sck = 1'h1;
            repeat (4) @(negedge clk);
            sck = 1'h0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'h1;
        si = ~si;
        repeat (16) @(negedge clk);
    endtask
endmodule

// file: dv/sfwp_monitor.sv
`timescale 1ns/1ps
module sfwp_monitor
    import sfwp_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CHIP_SEL_N,
    input wire logic WRITE_GUARD_N,
    input wire logic SER_OUT_EN,
    input wire logic [7:0] FLASH_STATUS,
    input wire logic QUAD_IO_ENABLE,
    input wire logic OP_START,
    input wire logic [7:0] OP_CMD,
    input wire logic [23:0] OP_ADDR
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    wire logic [3:0] prot = FLASH_STATUS[5:2];
    // size 64 for code 7 covers the whole array from either end
    function automatic logic hit(input logic [3:0] c, input logic [5:0] b);
        int s;
        s = (c[2:0] == 3'h0) ? 0 : 1 << (c[2:0] - 1);
        return c[3] ? (b < s) : (64 - b <= s);
    endfunction
    sequence busy_hold;
        FLASH_STATUS[BIT_BUSY] [*8];
    endsequence
    busy_hold_a: assert property (OP_START |=> busy_hold)
        else $error("busy not held after op start");
    start_latch_a: assert property (OP_START |-> FLASH_STATUS[BIT_LATCH])
        else $error("op started without write latch");
    start_cs_a: assert property (OP_START |-> CHIP_SEL_N)
        else $error("op started while selected");
    full_erase_a: assert property ((OP_START && (OP_CMD == CMD_FULL_ERASE_A ||
        OP_CMD == CMD_FULL_ERASE_B)) |-> prot == 4'h0) else $error("full erase with protection");
    prot_range_a: assert property (OP_START |-> !hit(prot, OP_ADDR[BLK_MSB:BLK_LSB]))
        else $error("op started in protected block");
    quad_mirror_a: assert property ($changed(QUAD_IO_ENABLE) |-> $past(FLASH_STATUS[BIT_LATCH]))
        else $error("quad enable changed without write latch");
    status_busy_a: assert property ($changed(FLASH_STATUS[7:2]) |-> FLASH_STATUS[BIT_BUSY])
        else $error("status changed without busy");
    lock_guard_a: assert property ((FLASH_STATUS[BIT_LOCK] && !WRITE_GUARD_N &&
        !$past(WRITE_GUARD_N) && !$past(WRITE_GUARD_N, 2)) |=> $stable(FLASH_STATUS[7:2]))
        else $error("locked status changed");
    read_release_a: assert property ($rose(CHIP_SEL_N) |-> ##[1:3] !SER_OUT_EN)
        else $error("readback still driving after deselect");
    latch_clear_a: assert property ($fell(FLASH_STATUS[BIT_BUSY])
        |-> ##[0:2] !FLASH_STATUS[BIT_LATCH]) else $error("latch kept after op");
endmodule
bind sfwp_core sfwp_monitor u_mon (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .CHIP_SEL_N(CHIP_SEL_N), .WRITE_GUARD_N(WRITE_GUARD_N), .SER_OUT_EN(SER_OUT_EN),
    .FLASH_STATUS(FLASH_STATUS),
    .QUAD_IO_ENABLE(QUAD_IO_ENABLE), .OP_START(OP_START), .OP_CMD(OP_CMD), .OP_ADDR(OP_ADDR));

// file: dv/test_serial_flash_write_protection.sv
`timescale 1ns/1ps
module test_serial_flash_write_protection
    import sfwp_pkg::*;
;
    typedef struct packed {logic [3:0] code; logic [7:0] cmd; logic [5:0] blk; logic go;} sfwp_row_t;
    logic core_clk, rst_n, guard_n, op_done;
    wire logic cs_n, sck, si, quad, op_start, ser_out;
    wire logic [7:0] status;
    int miscompares = 0, tests_run = 0, op_cnt = 0, base;
    sfwp_row_t rows [16] = '{{4'h0, 8'hD8, 6'h3F, 1'h1}, {4'h1, 8'hD8, 6'h3F, 1'h0},
        {4'h1, 8'h20, 6'h3E, 1'h1}, {4'h6, 8'hD7, 6'h20, 1'h0}, {4'h6, 8'h02, 6'h1F, 1'h1},
        {4'h7, 8'h32, 6'h00, 1'h0}, {4'h9, 8'hD8, 6'h00, 1'h0}, {4'h9, 8'hD8, 6'h01, 1'h1},
        {4'hE, 8'h20, 6'h1F, 1'h0}, {4'hE, 8'h02, 6'h20, 1'h1}, {4'hF, 8'hD8, 6'h28, 1'h0},
        {4'h8, 8'hC7, 6'h00, 1'h0}, {4'h0, 8'h60, 6'h00, 1'h1}, {4'h5, 8'hD8, 6'h30, 1'h0},
        {4'hC, 8'hD8, 6'h08, 1'h1}, {4'h3, 8'hD8, 6'h3B, 1'h1}};
    sfwp_host host (.clk(core_clk), .so(ser_out), .cs_n(cs_n), .sck(sck), .si(si));
    sfwp_core DUT (.CORE_CLK(core_clk), .RST_N(rst_n), .CHIP_SEL_N(cs_n), .SER_CLK(sck),
        .SER_IN(si), .WRITE_GUARD_N(guard_n), .SER_OUT(ser_out), .SER_OUT_EN(),
        .FLASH_STATUS(status),
        .QUAD_IO_ENABLE(quad), .OP_START(op_start), .OP_CMD(), .OP_ADDR(), .OP_DONE(op_done));
    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (op_start === 1'h1) op_cnt++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_idle;
        for (int j = 0; j < 400 && status[BIT_BUSY] !== 1'h0; j++) @(negedge core_clk);
    endtask
    task automatic set_status(input logic [7:0] v, input int n);
        host.frame({24'h00_0000, CMD_WRITE_ARM}, 8);
        // command stays in the first byte whatever the clock count
        host.frame({CMD_STATUS_WRITE, v, 16'h0000} >> (32 - n), n);
        wait_idle();
    endtask
    initial begin
        repeat (60000) @(negedge core_clk);
        miscompares++;
        conclude();
    end
    initial begin
        rst_n = 1'h0;
        guard_n = 1'h1;
        op_done = 1'h1;
        repeat (8) @(negedge core_clk);
        rst_n = 1'h1;
        repeat (4) @(negedge core_clk);
        check(status, STATUS_RESET);
        check(quad, 1'h0);
        foreach (rows[k]) begin
            set_status({2'h0, rows[k].code, 2'h0}, 16);
            check(status, {2'h0, rows[k].code, 2'h0});
            host.frame({24'h00_0000, CMD_WRITE_ARM}, 8);
            base = op_cnt;
            if (rows[k].cmd == CMD_FULL_ERASE_A || rows[k].cmd == CMD_FULL_ERASE_B)
                host.frame({24'h00_0000, rows[k].cmd}, 8);
            else
                host.frame({rows[k].cmd, 2'h0, rows[k].blk, 16'h1234}, 32);
            wait_idle();
            check(op_cnt - base, rows[k].go);
            check(status[BIT_LATCH], !rows[k].go);
        end
        host.frame({16'h0000, CMD_STATUS_WRITE, 8'h00}, 16);
        check(status, 8'h0C);
        host.frame({24'h00_0000, CMD_WRITE_ARM}, 8);
        check(status, 8'h0E);
        host.frame({24'h00_0000, CMD_WRITE_DISARM}, 8);
        check(status, 8'h0C);
        set_status(8'h00, 15);
        check(status, 8'h0E);
        set_status(8'h00, 17);
        check(status, 8'h0E);
        set_status(8'hC0, 16);
        check(status, 8'hC0);
        check(quad, 1'h1);
        host.frame({16'h0000, CMD_READ_STATUS, 8'h00}, 16);
        check(host.rx[7:0], 8'hC0);
        guard_n = 1'h0;
        set_status(8'h00, 16);
        check(status, 8'hC2);
        guard_n = 1'h1;
        set_status(8'h00, 16);
        check(status, 8'h00);
        // array still working holds busy past the fixed count
        op_done = 1'h0;
        host.frame({24'h00_0000, CMD_WRITE_ARM}, 8);
        host.frame({CMD_BLOCK_ERASE, 24'h00_0000}, 32);
        repeat (120) @(negedge core_clk);
        check(status, 8'h03);
        op_done = 1'h1;
        wait_idle();
        check(status, 8'h00);
        // reset in mid-run drops the armed latch
        host.frame({24'h00_0000, CMD_WRITE_ARM}, 8);
        check(status, 8'h02);
        rst_n = 1'h0;
        repeat (8) @(negedge core_clk);
        rst_n = 1'h1;
        repeat (4) @(negedge core_clk);
        check(status, STATUS_RESET);
        conclude();
    end
endmodule
